// ==== pibc_pkg.sv ====
package pibc_pkg;

	// Device selection code on the device number lines, 140 octal.
	localparam logic [6:0] SEL_CODE = 7'h60;

	// Positions on the six data lines; index 5 is bus bit 30.
	localparam int B30 = 5;
	localparam int B31 = 4;
	localparam int B32 = 3;
	localparam int B33 = 2;
	localparam int B34 = 1;
	localparam int B35 = 0;
	localparam int CH_HI = 2;
	localparam int CH_LO = 0;

	// Strobe positions inside the synchronised strobe vector.
	localparam int STB_COC = 5;
	localparam int STB_COS = 4;
	localparam int STB_CI  = 3;
	localparam int STB_DOC = 2;
	localparam int STB_DOS = 1;
	localparam int STB_RST = 0;

	// Timing, in nanoseconds, and the clock period.
	localparam int unsigned CLK_NS   = 50;
	localparam int unsigned HOLD_NS  = 2500000;
	localparam int unsigned MOVE_NS  = 2500000;
	localparam int unsigned RAISE_NS = 7500000;
	localparam int unsigned LOWER_NS = 30000000;
	localparam int CNT_W = 20;

	// Reset values.
	localparam logic [2:0] CHAN_RST = 3'h0;
	localparam logic [5:0] FUNC_RST = 6'h00;
	localparam logic [6:0] IRQ_RST  = 7'h00;

	// Sequencer states, one-hot.
	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_HOLD  = 6'h02,
		ST_MOVE  = 6'h04,
		ST_RAISE = 6'h08,
		ST_LOW1  = 6'h10,
		ST_LOW2  = 6'h20
	} pibc_state_t;

endpackage

// ==== pibc_top.sv ====
// What this block does
// - Power application clears busy, done, channel.
// - Clear held until power-up indication arrives.
// - Act on strobes only when selected; bus reset always.
// - Selection code is 140 octal.
// - Selected clear strobe clears flags, channel.
// - Set strobe loads channel from bits 33-35.
// - Bit 32 on set: done, not busy.
// - Bit 31 on set: busy; independent bits.
// - Drive status only on selected status read.
// - Status: power, busy, done, channel bits.
// - Data-out clear: done off, busy, timing start.
// - Only bus bits 30 to 35 used.
// - Interrupt on one of seven lines.
// - Six mechanism outputs, one increment each.
// - Bus reset clears like condition-out clear.
// - Bit30 raise, 31 lower, 32-35 motions.
// - Motion: 2.5 ms active, 2.5 ms wait.
// - Raise: 2.5 ms active, 7.5 ms wait.
// - Lower: 2.5 ms active, two 30 ms.
`timescale 1ns/1ps
module pibc_top
	import pibc_pkg::*;
#(
	parameter int unsigned HOLD_CYC  = (HOLD_NS + CLK_NS - 1) / CLK_NS,
	parameter int unsigned MOVE_CYC  = (MOVE_NS + CLK_NS - 1) / CLK_NS,
	parameter int unsigned RAISE_CYC = (RAISE_NS + CLK_NS - 1) / CLK_NS,
	parameter int unsigned LOWER_CYC = (LOWER_NS + CLK_NS - 1) / CLK_NS
) (
	// Clock and reset.
	input  wire logic       CLK_I,
	input  wire logic       RST_N_I,
	// Bus selection and strobes.
	input  wire logic [6:0] DEV_NUM_I,
	input  wire logic       COND_OUT_CLEAR_I,
	input  wire logic       COND_OUT_SET_I,
	input  wire logic       COND_IN_STROBE_I,
	input  wire logic       DATA_OUT_CLEAR_I,
	input  wire logic       DATA_OUT_SET_I,
	input  wire logic       BUS_RESET_I,
	// Bus data lines 30 to 35.
	input  wire logic [5:0] DATA_I,
	output logic      [5:0] DATA_O,
	output logic            DATA_OE_N_O,
	// Power indications.
	input  wire logic       POWER_UP_I,
	input  wire logic       PLOTTER_POWER_I,
	// Priority interrupt lines 1 to 7, index 0 is line 1.
	output logic      [6:0] PRIORITY_INTERRUPT_O,
	// Mechanism drive.
	output logic            PEN_RAISE_O,
	output logic            PEN_LOWER_O,
	output logic            CARRIAGE_LEFT_O,
	output logic            CARRIAGE_RIGHT_O,
	output logic            DRUM_UP_O,
	output logic            DRUM_DOWN_O
);

	typedef struct packed {
		logic [20:0]      s1;
		logic [20:0]      s2;
		logic [5:0]       s3;
		logic             oneshot;
		logic             done;
		logic             busy;
		logic [2:0]       chan;
		logic [5:0]       func;
		pibc_state_t      state;
		logic [CNT_W-1:0] cnt;
		logic [6:0]       irq;
		logic [5:0]       stat;
		logic             oe_n;
	} pibc_regs_t;

	pibc_regs_t r_reg;
	pibc_regs_t r_next;

	logic [6:0] dev_s;
	logic [5:0] data_s;
	logic [5:0] stb_s;
	logic       pwrup_s;
	logic       ppwr_s;
	logic       sel;
	logic [5:0] rise;
	logic       coc_p;
	logic       cos_p;
	logic       doc_p;
	logic       dos_p;
	logic       clr;
	logic       fin;
	logic [6:0] irq_vec;

	// Second synchroniser stage feeds all logic; the first feeds only it.
	assign {dev_s, data_s, stb_s, pwrup_s, ppwr_s} = r_reg.s2;
	assign sel   = (dev_s == SEL_CODE);
	assign rise  = stb_s & ~r_reg.s3;
	assign coc_p = rise[STB_COC] & sel;
	assign cos_p = rise[STB_COS] & sel;
	assign doc_p = rise[STB_DOC] & sel;
	assign dos_p = rise[STB_DOS] & sel;
	// Bus reset needs no selection; it clears like the selected clear.
	assign clr = r_reg.oneshot | rise[STB_RST] | coc_p;
	assign fin = (r_reg.cnt == '0) & ((r_reg.state == ST_MOVE)
		| (r_reg.state == ST_RAISE) | (r_reg.state == ST_LOW2));

	// One decoder term per interrupt line; channel zero lights none.
	for (genvar i = 0; i < 7; i++) begin : g_irq
		assign irq_vec[i] = r_reg.done & (r_reg.chan == 3'(i + 1));
	end

	// Next-state logic for the whole block.
	always_comb begin
		r_next = r_reg;
		r_next.s1 = {DEV_NUM_I, DATA_I, COND_OUT_CLEAR_I, COND_OUT_SET_I,
			COND_IN_STROBE_I, DATA_OUT_CLEAR_I, DATA_OUT_SET_I,
			BUS_RESET_I, POWER_UP_I, PLOTTER_POWER_I};
		r_next.s2 = r_reg.s1;
		r_next.s3 = stb_s;
		// The one-shot drops once the power-up indication is seen.
		if (pwrup_s) begin
			r_next.oneshot = 1'b0;
		end
		// Sequencer; the counter counts down to zero in each timed state.
		unique case (r_reg.state)
			ST_IDLE: begin
				r_next.cnt = '0;
			end
			ST_HOLD: begin
				if (r_reg.cnt == '0) begin
					r_next.func = FUNC_RST;
					if (r_reg.func[B31]) begin
						r_next.state = ST_LOW1;
						r_next.cnt = CNT_W'(LOWER_CYC - 1);
					end else if (r_reg.func[B30]) begin
						r_next.state = ST_RAISE;
						r_next.cnt = CNT_W'(RAISE_CYC - 1);
					end else begin
						r_next.state = ST_MOVE;
						r_next.cnt = CNT_W'(MOVE_CYC - 1);
					end
				end else begin
					r_next.cnt = r_reg.cnt - 1'b1;
				end
			end
			ST_LOW1: begin
				if (r_reg.cnt == '0) begin
					r_next.state = ST_LOW2;
					r_next.cnt = CNT_W'(LOWER_CYC - 1);
				end else begin
					r_next.cnt = r_reg.cnt - 1'b1;
				end
			end
			ST_MOVE, ST_RAISE, ST_LOW2: begin
				if (r_reg.cnt == '0) begin
					r_next.state = ST_IDLE;
				end else begin
					r_next.cnt = r_reg.cnt - 1'b1;
				end
			end
			default: begin
				r_next.state = ST_IDLE;
				r_next.cnt = '0;
			end
		endcase
		// A new data-out clear restarts the active period.
		if (doc_p) begin
			r_next.state = ST_HOLD;
			r_next.cnt = CNT_W'(HOLD_CYC - 1);
		end
		if (dos_p) begin
			r_next.func = data_s;
		end
		// Clears come after the function load but before the flag and channel sets, which still win.
		if (clr) begin
			r_next.done = 1'b0;
			r_next.busy = 1'b0;
			r_next.chan = CHAN_RST;
			r_next.func = FUNC_RST;
			r_next.state = ST_IDLE;
			r_next.cnt = '0;
		end
		if (doc_p) begin
			r_next.done = 1'b0;
		end
		if (cos_p && data_s[B32]) begin
			r_next.busy = 1'b0;
		end
		if (fin) begin
			r_next.busy = 1'b0;
		end
		if (doc_p) begin
			r_next.busy = 1'b1;
		end
		if (cos_p) begin
			r_next.chan = data_s[CH_HI:CH_LO];
			if (data_s[B31]) begin
				r_next.busy = 1'b1;
			end
			if (data_s[B32]) begin
				r_next.done = 1'b1;
			end
		end
		if (fin) begin
			r_next.done = 1'b1;
		end
		r_next.irq = irq_vec;
		// Status is driven only while a selected status read is seen.
		r_next.stat = {ppwr_s, r_reg.busy, r_reg.done, r_reg.chan};
		r_next.oe_n = ~(stb_s[STB_CI] & sel);
	end

	// State register; the one-shot starts set, as at power application.
	always_ff @(posedge CLK_I) begin
		if (!RST_N_I) begin
			r_reg <= '0;
			r_reg.oneshot <= 1'b1;
			r_reg.state <= ST_IDLE;
			r_reg.oe_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign DATA_O           = r_reg.stat;
	assign DATA_OE_N_O      = r_reg.oe_n;
	assign PRIORITY_INTERRUPT_O = r_reg.irq;
	assign PEN_RAISE_O      = r_reg.func[B30];
	assign PEN_LOWER_O      = r_reg.func[B31];
	assign CARRIAGE_LEFT_O  = r_reg.func[B32];
	assign CARRIAGE_RIGHT_O = r_reg.func[B33];
	assign DRUM_UP_O        = r_reg.func[B34];
	assign DRUM_DOWN_O      = r_reg.func[B35];

	// Checks on the flags, the status gate and the sequencer.
	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (!RST_N_I);

	sequence s_timed_end(pibc_state_t st);
		r_reg.state == st && r_reg.cnt == '0 && !clr && !doc_p;
	endsequence

	chk_clear_flags: assert property (clr && !fin |=>
		!r_reg.done && !r_reg.busy && r_reg.chan == 3'h0)
		else $error("clear did not clear flags and channel");
	chk_oneshot_hold: assert property (r_reg.oneshot && !pwrup_s |=>
		r_reg.oneshot) else $error("one-shot released early");
	chk_strobe_pulse: assert property (coc_p || dos_p |=>
		!coc_p && !dos_p) else $error("strobe pulse longer than a cycle");
	chk_chan_load: assert property (cos_p && !clr |=>
		r_reg.chan == $past(data_s[CH_HI:CH_LO]))
		else $error("channel not loaded");
	chk_cos_done: assert property (cos_p && data_s[B32] && !clr |=>
		r_reg.done) else $error("done not set by bit 32");
	chk_cos_busy: assert property (cos_p && data_s[B31] && !clr |=>
		r_reg.busy) else $error("busy not set by bit 31");
	chk_status_gate: assert property (!DATA_OE_N_O |->
		$past(stb_s[STB_CI] && sel))
		else $error("status driven without selected read");
	chk_status_bits: assert property (!DATA_OE_N_O |->
		DATA_O == $past({ppwr_s, r_reg.busy, r_reg.done, r_reg.chan}))
		else $error("status bits wrong");
	chk_doc_start: assert property (doc_p && !clr |=>
		r_reg.busy && !r_reg.done && r_reg.state == ST_HOLD
		&& r_reg.cnt == CNT_W'(HOLD_CYC - 1))
		else $error("data-out clear did not start timing");
	chk_irq_line: assert property (##1
		$onehot0(PRIORITY_INTERRUPT_O) && ((PRIORITY_INTERRUPT_O != 7'h00)
		== $past(r_reg.done && r_reg.chan != 3'h0)))
		else $error("interrupt line wrong");
	chk_move_end: assert property (s_timed_end(ST_MOVE) |=>
		r_reg.done && !r_reg.busy && r_reg.state == ST_IDLE)
		else $error("motion did not finish");
	chk_raise_wait: assert property (s_timed_end(ST_HOLD) ##0
		(r_reg.func[B30] && !r_reg.func[B31]) |=> r_reg.state == ST_RAISE
		&& r_reg.cnt == CNT_W'(RAISE_CYC - 1) && !PEN_RAISE_O)
		else $error("raise wait not started");
	chk_lower_two: assert property (s_timed_end(ST_LOW1) |=>
		r_reg.state == ST_LOW2 && r_reg.cnt == CNT_W'(LOWER_CYC - 1)
		&& !r_reg.done) else $error("second lower delay not started");

endmodule

// ==== pibc_cpu.sv ====
`timescale 1ns/1ps
// Processor side of the bus: raises strobes with selection and data.
module pibc_cpu
	import pibc_pkg::*;
(
	// Clock.
	input  wire logic       clk_i,
	// Bus drive.
	output logic      [6:0] dev_num_o,
	output logic      [5:0] strobe_o,
	output logic      [5:0] data_o
);
	// Idle bus: nothing selected, no strobe.
	initial begin
		dev_num_o = ~SEL_CODE;
		strobe_o  = 6'h00;
		data_o    = 6'h00;
	end

	// One strobe, called at a falling edge; qualifiers hold until it drops.
	// Released lines show the inverse so stale data is never read as valid.
	task automatic op(input int s, input logic [6:0] dv,
		input logic [5:0] d, input int hi, input int lo);
		dev_num_o = dv;
		data_o    = d;
		strobe_o  = 6'h01 << s;
		repeat (hi) @(negedge clk_i);
		strobe_o  = 6'h00;
		dev_num_o = ~SEL_CODE;
		data_o    = ~d;
		repeat (lo) @(negedge clk_i);
	endtask

	// Clear then set, the set raised 20 cycles (1 us) after the clear.
	task automatic pair(input int c, input int s, input logic [5:0] d);
		op(c, SEL_CODE, 6'h00, 3, 17);
		op(s, SEL_CODE, d, 3, 3);
	endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/1ps
module tb;
	import pibc_pkg::*;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        pwr_up = 1'b0;
	logic        plot_pwr = 1'b1;
	logic [6:0]  dev;
	logic [5:0]  stb;
	logic [5:0]  din;
	logic [5:0]  dout;
	logic [5:0]  mech;
	logic        oe_n;
	logic        prev_oe_n = 1'b1;
	logic [6:0]  irq;
	logic [12:0] expq[$];
	logic [31:0] r;
	logic [5:0]  d;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	int          seed = 32'h3f1d;
	int          t0;
	int          cyc;
	int          e;
	int          n;

	// Short counts keep the run brief; expectations use the same values.
	pibc_top #(.HOLD_CYC(40), .MOVE_CYC(40), .RAISE_CYC(60),
		.LOWER_CYC(80)) u_pibc_top (
		.CLK_I(clk), .RST_N_I(rst_n), .DEV_NUM_I(dev),
		.COND_OUT_CLEAR_I(stb[STB_COC]), .COND_OUT_SET_I(stb[STB_COS]),
		.COND_IN_STROBE_I(stb[STB_CI]), .DATA_OUT_CLEAR_I(stb[STB_DOC]),
		.DATA_OUT_SET_I(stb[STB_DOS]), .BUS_RESET_I(stb[STB_RST]),
		.DATA_I(din), .DATA_O(dout), .DATA_OE_N_O(oe_n),
		.POWER_UP_I(pwr_up), .PLOTTER_POWER_I(plot_pwr),
		.PRIORITY_INTERRUPT_O(irq),
		.PEN_RAISE_O(mech[5]), .PEN_LOWER_O(mech[4]),
		.CARRIAGE_LEFT_O(mech[3]), .CARRIAGE_RIGHT_O(mech[2]),
		.DRUM_UP_O(mech[1]), .DRUM_DOWN_O(mech[0]));

	pibc_cpu u_pibc_cpu (.clk_i(clk), .dev_num_o(dev), .strobe_o(stb),
		.data_o(din));

	// Free running 20 MHz clock.
	initial begin
		forever #25 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [12:0] x,
		input logic [12:0] g);
		cmp_count++;
		if (g !== x) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic final_report;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Status read: the expected word is noted before the strobe goes out.
	task automatic rd(input logic [12:0] x);
		expq.push_back(x);
		u_pibc_cpu.op(STB_CI, SEL_CODE, 6'h00, 6, 6);
	endtask

	// Each time the status drive opens, the oldest note is compared.
	always @(negedge clk) begin
		if (oe_n === 1'b0 && prev_oe_n === 1'b1) begin
			if (expq.size() == 0) chk("stray", 13'h1FFF, {irq, dout});
			else chk("status", expq.pop_front(), {irq, dout});
		end
		prev_oe_n <= oe_n;
	end

	// Watchdog, far beyond the 1300 or so cycles the tests need.
	initial begin
		#(20000 * 50);
		n_mismatch++;
		final_report();
	end

	// Main sequence.
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		pwr_up = 1'b1;
		repeat (6) @(negedge clk);
		rd({7'h00, 6'h20});
		plot_pwr = 1'b0;
		rd({7'h00, 6'h00});
		plot_pwr = 1'b1;
		r = $random(seed);
		if (r[6:0] == SEL_CODE) r[0] = ~r[0];
		u_pibc_cpu.op(STB_COS, r[6:0], 6'h1F, 3, 3);
		u_pibc_cpu.op(STB_CI, r[6:0], 6'h00, 6, 6);
		rd({7'h00, 6'h20});
		for (int c = 0; c < 8; c++) begin
			r = $random(seed);
			u_pibc_cpu.pair(STB_COC, STB_COS, {1'b0, r[1:0], c[2:0]});
			rd({(r[0] && c != 0) ? 7'h01 << (c - 1) : 7'h00,
				1'b1, r[1:0], c[2:0]});
		end
		u_pibc_cpu.op(STB_COC, SEL_CODE, 6'h00, 3, 3);
		rd({7'h00, 6'h20});
		u_pibc_cpu.pair(STB_COC, STB_COS, 6'h0D);
		u_pibc_cpu.op(STB_RST, ~SEL_CODE, 6'h00, 3, 3);
		rd({7'h00, 6'h20});
		for (int k = 0; k < 6; k++) begin
			u_pibc_cpu.pair(STB_COC, STB_COS, 6'h0D);
			d = 6'h01 << k;
			t0 = int'($time);
			u_pibc_cpu.pair(STB_DOC, STB_DOS, d | 6'h00);
			chk("mech", {7'h00, d}, {7'h00, mech});
			rd({7'h00, 6'h35});
			n = 0;
			while (irq === 7'h00 && n < 400) begin
				@(negedge clk);
				n++;
			end
			cyc = (int'($time) - t0) / 50;
			e = 45 + ((k == 5) ? 60 : (k == 4) ? 160 : 40);
			cmp_count++;
			if (cyc < e - 3 || cyc > e + 3) begin
				n_mismatch++;
				$display("Error done_delay expected %0d seen %0d", e, cyc);
			end
			chk("mech", 13'h0000, {7'h00, mech});
			rd({7'h10, 6'h2D});
		end
		final_report();
	end
endmodule
